// >>> hw/fct_regbank.sv
/*
  Fault capture mask, output voltage fault filter and external temperature
  calibration, reached by command code from the transaction layer.
  Assumes command, detector and temperature inputs share sys_clk.
*/
// Operation
// - A set mask bit stops that fault type from raising the capture event.
// - The capture mask is sixteen bits and resets to zero.
// - Mask bits 15..11: phase, group, processor, under-temp, over-temp faults.
// - Mask bits 10, 9, 8: peak overcurrent, peak undercurrent, enable fault bus.
// - Bits 7, 6, 5: input OV, output OV, output UV; bit 4 unused.
// - Bits 3..0: sync loss, input UV, average overcurrent, average undercurrent.
// - Output OV or UV fault declared after N+1 consecutive violations, N in bits 3:0.
// - Voltage filter byte: bits 7:4 unused, reset value zero.
// - Temperature readback is measured temperature divided by scale, minus offset.
// - A scale write outside 0.1 to 10 is refused and old value kept.
// - The scale is Linear-11 and resets to BA00h, meaning 1.0.
// - The offset is Linear-11 in degrees and resets to zero.
// - An offset write beyond the allowed range is refused and old value kept.
`default_nettype none
`include "fct_regs.svh"

module fct_regbank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Command port
  input wire fct_pkg::fct_cmd_t cmd,
  output var fct_pkg::fct_rsp_t rsp,
  // Fault capture
  input wire logic [15:0] fault_event,
  output logic cap_event,
  output logic [15:0] cap_cause,
  // Output voltage limit samples
  input wire fct_pkg::fct_vsample_t vsample,
  output logic ov_fault,
  output logic uv_fault,
  // External temperature
  input wire logic ext_temp_valid,
  input wire logic signed [15:0] ext_temp,
  output logic temp_busy,
  output logic temp_valid,
  output logic signed [15:0] temp_readback
);

  // ========================================================================
  // Helpers

  // Exponent plus sixteen wraps to {~e[4], e[3:0]}, so the shift is exact.
  function automatic logic signed [47:0] lin11_q16(input logic [15:0] w);
    logic signed [47:0] y;
    y = 48'($signed(w[`FCT_LIN_MAN_HI:0]));
    return y <<< {~w[`FCT_LIN_EXP_HI], w[`FCT_LIN_EXP_HI-1:`FCT_LIN_EXP_LO]};
  endfunction : lin11_q16

  function automatic logic [5:0] vfilt(input logic valid, input logic viol, input logic [4:0] cnt,
                                       input logic flt, input logic [4:0] lim);
    logic [4:0] inc;
    inc = (cnt == 5'h1F) ? cnt : 5'(cnt + 5'h01);
    if (!valid) begin
      return {cnt, flt};
    end else if (!viol) begin
      return 6'h00;
    end
    return {inc, flt | (cnt == lim)};
  endfunction : vfilt

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh000000007FFF) begin
      return 16'sh7FFF;
    end else if (v < -48'sh000000008000) begin
      return -16'sh8000;
    end
    return 16'(v);
  endfunction : sat16

  localparam fct_pkg::fct_state_t ST_RST = '{
    mask: `FCT_MASK_RST,
    vcfg: `FCT_VCFG_RST,
    scale: `FCT_SCALE_RST,
    offset: `FCT_OFFSET_RST,
    phase: fct_pkg::fct_idle,
    default: '0
  };

  fct_pkg::fct_state_t st;
  fct_pkg::fct_state_t nx;
  logic signed [47:0] scale_q;
  logic signed [47:0] off_q;
  logic signed [47:0] wr_q;
  logic signed [47:0] res;
  logic scale_ok;
  logic off_ok;
  logic [15:0] hits;
  logic [4:0] n_lim;
  logic [32:0] trial;
  logic [15:0] mag;

  // ========================================================================
  // Next state

  always_comb begin
    nx = st;
    nx.rsp.ack = 1'b0;
    nx.rsp.err = 1'b0;
    nx.temp_vld = 1'b0;
    scale_q = lin11_q16(st.scale);
    off_q = lin11_q16(st.offset);
    wr_q = lin11_q16(cmd.wdata);
    scale_ok = (wr_q >= $signed(`FCT_SCALE_MIN)) && (wr_q <= $signed(`FCT_SCALE_MAX));
    off_ok = (wr_q >= $signed(`FCT_OFF_MIN)) && (wr_q <= $signed(`FCT_OFF_MAX));
    n_lim = {1'b0, st.vcfg[`FCT_VCFG_N_HI:0]};
    trial = {st.rem[31:0], st.quo[31]};
    mag = ext_temp[15] ? 16'(-ext_temp) : ext_temp;
    res = '0;

    // Command port: writes store, reads answer one cycle later.
    if (cmd.wr) begin
      nx.rsp.ack = 1'b1;
      case (cmd.code)
        `FCT_CODE_MASK: begin
          nx.mask = cmd.wdata;
        end
        `FCT_CODE_VCFG: begin
          nx.vcfg = {4'h0, cmd.wdata[`FCT_VCFG_N_HI:0]};
        end
        `FCT_CODE_SCALE: begin
          if (scale_ok) begin
            nx.scale = cmd.wdata;
          end else begin
            nx.rsp.err = 1'b1;
          end
        end
        `FCT_CODE_OFFSET: begin
          if (off_ok) begin
            nx.offset = cmd.wdata;
          end else begin
            nx.rsp.err = 1'b1;
          end
        end
        default: begin
          nx.rsp.err = 1'b1;
        end
      endcase
    end else if (cmd.rd) begin
      nx.rsp.ack = 1'b1;
      case (cmd.code)
        `FCT_CODE_MASK: nx.rsp.rdata = st.mask;
        `FCT_CODE_VCFG: nx.rsp.rdata = {8'h00, st.vcfg};
        `FCT_CODE_SCALE: nx.rsp.rdata = st.scale;
        `FCT_CODE_OFFSET: nx.rsp.rdata = st.offset;
        default: begin
          nx.rsp.rdata = 16'h0000;
          nx.rsp.err = 1'b1;
        end
      endcase
    end

    // Capture trigger: bit 4 has no fault behind it, so it never fires.
    hits = fault_event & ~st.mask & `FCT_MASK_LIVE;
    nx.cap_evt = |hits;
    nx.cap_cause = hits;

    // Consecutive violation filters for output over- and undervoltage.
    {nx.ov_cnt, nx.ov_fault} = vfilt(vsample.valid, vsample.over, st.ov_cnt, st.ov_fault, n_lim);
    {nx.uv_cnt, nx.uv_fault} = vfilt(vsample.valid, vsample.under, st.uv_cnt, st.uv_fault, n_lim);

    // Readback is a 32-step restoring divide; one bit per clock keeps the
    // area small at the price of 34 cycles of latency.
    case (st.phase)
      fct_pkg::fct_idle: begin
        if (ext_temp_valid) begin
          nx.phase = fct_pkg::fct_div;
          nx.steps = 6'h00;
          nx.neg = ext_temp[15];
          nx.quo = {mag, 16'h0000};
          nx.rem = '0;
          nx.den = scale_q[31:0];
        end
      end
      fct_pkg::fct_div: begin
        nx.quo = {st.quo[30:0], 1'b0};
        if (trial >= {1'b0, st.den}) begin
          nx.rem = trial - {1'b0, st.den};
          nx.quo[0] = 1'b1;
        end else begin
          nx.rem = trial;
        end
        nx.steps = 6'(st.steps + 6'h01);
        if (st.steps == `FCT_DIV_LAST) begin
          nx.phase = fct_pkg::fct_fin;
        end
      end
      fct_pkg::fct_fin: begin
        res = st.neg ? -48'(st.quo) : 48'(st.quo);
        res = res - (off_q >>> `FCT_TEMP_TO_Q16);
        nx.temp = sat16(res);
        nx.temp_vld = 1'b1;
        nx.phase = fct_pkg::fct_idle;
      end
      default: begin
        nx.phase = fct_pkg::fct_idle;
      end
    endcase
  end

  // ========================================================================
  // State register

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign rsp = st.rsp;
  assign cap_event = st.cap_evt;
  assign cap_cause = st.cap_cause;
  assign ov_fault = st.ov_fault;
  assign uv_fault = st.uv_fault;
  assign temp_busy = (st.phase != fct_pkg::fct_idle);
  assign temp_valid = st.temp_vld;
  assign temp_readback = st.temp;

  // ========================================================================
  // Checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_div_start;
    st.phase == fct_pkg::fct_idle && ext_temp_valid;
  endsequence

  sequence s_div_run;
    (st.phase == fct_pkg::fct_div) [*8] ##25 (st.phase == fct_pkg::fct_fin) ##1 st.temp_vld;
  endsequence

  chk_mask_blocks: assert property (
    (fault_event != 16'h0000) && ((fault_event & ~st.mask & `FCT_MASK_LIVE) == 16'h0000) |=> !st.cap_evt)
    else $error("masked fault raised the capture event");

  chk_capture_fires: assert property (
    ((fault_event & ~st.mask & `FCT_MASK_LIVE) != 16'h0000) |=> st.cap_evt && (st.cap_cause != 16'h0000))
    else $error("unmasked fault did not raise the capture event");

  chk_unused_bit: assert property (
    fault_event == 16'h0010 |=> !st.cap_evt)
    else $error("unused mask position raised the capture event");

  chk_regs_reset: assert property (
    $rose(reset_n) |-> st.mask == `FCT_MASK_RST && st.scale == `FCT_SCALE_RST && st.offset == `FCT_OFFSET_RST)
    else $error("register reset value wrong");

  chk_vcfg_write: assert property (
    cmd.wr && cmd.code == `FCT_CODE_VCFG |=> st.vcfg == {4'h0, 4'($past(cmd.wdata))})
    else $error("voltage filter byte wrong after write");

  chk_ov_declare: assert property (
    $rose(st.ov_fault) |-> $past(st.ov_cnt) == $past(n_lim) && $past(vsample.over))
    else $error("overvoltage fault declared at wrong count");

  chk_run_break: assert property (
    vsample.valid && !vsample.over |=> st.ov_cnt == 5'h00 && !st.ov_fault)
    else $error("violation counter not cleared by a good sample");

  chk_uv_declare: assert property (
    $rose(st.uv_fault) |-> $past(st.uv_cnt) == $past(n_lim) && $past(vsample.under))
    else $error("undervoltage fault declared at wrong count");

  chk_uv_break: assert property (
    vsample.valid && !vsample.under |=> st.uv_cnt == 5'h00 && !st.uv_fault)
    else $error("undervoltage counter not cleared by a good sample");

  chk_scale_store: assert property (
    cmd.wr && cmd.code == `FCT_CODE_SCALE && scale_ok |=> st.scale == $past(cmd.wdata))
    else $error("accepted scale not stored");

  chk_offset_store: assert property (
    cmd.wr && cmd.code == `FCT_CODE_OFFSET && off_ok |=> st.offset == $past(cmd.wdata))
    else $error("accepted offset not stored");

  chk_scale_keep: assert property (
    cmd.wr && cmd.code == `FCT_CODE_SCALE && !scale_ok |=> $stable(st.scale) && st.rsp.err)
    else $error("out of range scale accepted");

  chk_offset_keep: assert property (
    cmd.wr && cmd.code == `FCT_CODE_OFFSET && !off_ok |=> $stable(st.offset) && st.rsp.err)
    else $error("out of range offset accepted");

  chk_lin11_one: assert property (
    st.scale == `FCT_SCALE_RST |-> scale_q == $signed(`FCT_Q16_ONE))
    else $error("unit scale decoded wrongly");

  chk_div_latency: assert property (
    s_div_start |=> s_div_run)
    else $error("temperature readback not ready on time");

endmodule : fct_regbank

`default_nettype wire

// >>> hw/fct_regs.svh
/*
  Command codes, field positions, reset values and limits of the fault
  capture mask and external temperature calibration block.
  Assumes it is included by bare name wherever these values are needed.
*/
`ifndef FCT_REGS_SVH
`define FCT_REGS_SVH

// ==========================================================================
// Command codes
`define FCT_CODE_MASK 8'hD7
`define FCT_CODE_VCFG 8'hD8
`define FCT_CODE_SCALE 8'hD9
`define FCT_CODE_OFFSET 8'hDA

// ==========================================================================
// Reset values
`define FCT_MASK_RST 16'h0000
`define FCT_VCFG_RST 8'h00
`define FCT_SCALE_RST 16'hBA00
`define FCT_OFFSET_RST 16'h0000

// ==========================================================================
// Fields
`define FCT_MASK_LIVE 16'hFFEF
`define FCT_VCFG_N_HI 3
`define FCT_LIN_EXP_HI 15
`define FCT_LIN_EXP_LO 11
`define FCT_LIN_MAN_HI 10

// ==========================================================================
// Limits in signed fixed point with 16 fraction bits
`define FCT_SCALE_MIN 48'h00000000199A
`define FCT_SCALE_MAX 48'h0000000A0000
`define FCT_OFF_MAX 48'h000000640000
`define FCT_OFF_MIN 48'hFFFFFF9C0000
`define FCT_Q16_ONE 48'h000000010000

// ==========================================================================
// Temperature path
`define FCT_TEMP_TO_Q16 12
`define FCT_DIV_LAST 6'h1F

`endif

// >>> hw/fct_pkg.sv
/*
  Types shared by the fault capture mask and temperature calibration block.
  Assumes the command layer and detectors run on the same clock.
*/
`default_nettype none

package fct_pkg;

  // ========================================================================
  // Carriers
  typedef enum logic [1:0] {fct_idle, fct_div, fct_fin} fct_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } fct_cmd_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } fct_rsp_t;

  typedef struct packed {
    logic valid;
    logic over;
    logic under;
  } fct_vsample_t;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [15:0] mask;
    logic [7:0] vcfg;
    logic [15:0] scale;
    logic [15:0] offset;
    logic [4:0] ov_cnt;
    logic [4:0] uv_cnt;
    logic ov_fault;
    logic uv_fault;
    logic cap_evt;
    logic [15:0] cap_cause;
    fct_rsp_t rsp;
    fct_phase_t phase;
    logic [5:0] steps;
    logic neg;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [31:0] den;
    logic [15:0] temp;
    logic temp_vld;
  } fct_state_t;

endpackage : fct_pkg

`default_nettype wire

// >>> verification/fct_host_model.sv
/*
  Host-side model that issues register commands to the calibration block.
  Assumes the bench calls xfer and that the block answers one cycle later.
*/
`default_nettype none

module fct_host_model (
  // Clock
  input wire logic sys_clk,
  // Command side of the block
  output var fct_pkg::fct_cmd_t cmd,
  input wire fct_pkg::fct_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Transfers
  initial cmd = '0;

  // Released lines show the inverse of the last value so a stale code is never a free match.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output fct_pkg::fct_rsp_t r);
    @(negedge sys_clk);
    cmd = '{wr: w, rd: !w, code: c, wdata: d};
    @(negedge sys_clk);
    r = rsp;
    cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
  endtask : xfer
endmodule : fct_host_model

`default_nettype wire

// >>> verification/fault_mask_and_temp_calibration_tb_top.sv
/*
  Self-checking bench of fct_regbank against a behavioural model.
  Assumes fct_pkg and the host model are compiled first.
*/
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, a); end end

module fault_mask_and_temp_calibration_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals and model state
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ext_temp_valid = 1'b0;
  logic temp_busy, temp_valid, cap_event, ov_fault, uv_fault;
  logic [15:0] fault_event = 16'h0000;
  logic [15:0] ext_temp = 16'h0000;
  logic [15:0] cap_cause, temp_readback;
  fct_pkg::fct_cmd_t cmd;
  fct_pkg::fct_rsp_t rsp;
  fct_pkg::fct_vsample_t vsample = '0;
  logic [15:0] m_mask = 16'h0000;
  logic [15:0] m_scale = 16'hBA00;
  logic [15:0] m_off = 16'h0000;
  logic [3:0] m_n = 4'h0;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 89658;
  int c_ov = 0;
  int c_uv = 0;

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  fct_regbank dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd), .rsp(rsp), .fault_event(fault_event),
    .cap_event(cap_event), .cap_cause(cap_cause), .vsample(vsample), .ov_fault(ov_fault), .uv_fault(uv_fault),
    .ext_temp_valid(ext_temp_valid), .ext_temp(ext_temp), .temp_busy(temp_busy), .temp_valid(temp_valid),
    .temp_readback(temp_readback));

  fct_host_model host (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp));

  // ==========================================================================
  // Model
  function automatic longint lin(input logic [15:0] w);
    longint y;
    int n;
    y = $signed(w[10:0]);
    n = $signed(w[15:11]);
    return n >= 0 ? (y <<< (16 + n)) : ((y <<< 16) >>> (-n));
  endfunction : lin

  function automatic logic [15:0] ev(input logic [7:0] c);
    case (c)
      8'hD7: return m_mask;
      8'hD8: return {12'h000, m_n};
      8'hD9: return m_scale;
      8'hDA: return m_off;
      default: return 16'h0000;
    endcase
  endfunction : ev

  // ==========================================================================
  // Drivers
  task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] d);
    fct_pkg::fct_rsp_t r;
    logic e;
    longint v;
    v = lin(d);
    e = !(c inside {[8'hD7:8'hDA]});
    if (w && c == 8'hD9 && (v < 6554 || v > 655360)) e = 1'b1;
    if (w && c == 8'hDA && (v < -6553600 || v > 6553600)) e = 1'b1;
    host.xfer(w, c, d, r);
    `CHK("ack", 1'b1, r.ack)
    `CHK("err", e, r.err)
    if (!w) `CHK("rdata", ev(c), r.rdata)
    if (w && !e) begin
      case (c)
        8'hD7: m_mask = d;
        8'hD8: m_n = d[3:0];
        8'hD9: m_scale = d;
        default: m_off = d;
      endcase
    end
  endtask : xf

  task automatic cap(input logic [15:0] f);
    logic [15:0] x;
    x = f & ~m_mask & 16'hFFEF;
    @(negedge sys_clk);
    fault_event = f;
    @(negedge sys_clk);
    `CHK("cause", x, cap_cause)
    `CHK("event", |x, cap_event)
  endtask : cap

  // Invalid cycles carry inverted flags: the filter must ignore them.
  task automatic vs(input logic o, input logic u);
    @(negedge sys_clk);
    vsample = {1'b1, o, u};
    c_ov = o ? c_ov + 1 : 0;
    c_uv = u ? c_uv + 1 : 0;
    @(negedge sys_clk);
    vsample = {1'b0, ~o, ~u};
    `CHK("ov", c_ov > m_n, ov_fault)
    `CHK("uv", c_uv > m_n, uv_fault)
    if ($random(seed) & 1) @(negedge sys_clk);
  endtask : vs

  task automatic tp(input logic [15:0] t);
    longint a, q;
    int i;
    a = longint'($signed(t));
    q = ((a < 0 ? -a : a) * 65536) / lin(m_scale);
    q = (a < 0 ? -q : q) - (lin(m_off) >>> 12);
    q = q > 32767 ? 32767 : (q < -32768 ? -32768 : q);
    @(negedge sys_clk);
    ext_temp = t;
    ext_temp_valid = 1'b1;
    @(negedge sys_clk);
    // A second start offered while busy must be dropped without effect.
    ext_temp = ~t;
    `CHK("busy", 1'b1, temp_busy)
    @(negedge sys_clk);
    ext_temp_valid = 1'b0;
    for (i = 2; i < 40 && temp_valid !== 1'b1; i++) @(negedge sys_clk);
    `CHK("latency", 34, i)
    `CHK("temp", 16'(q), temp_readback)
    `CHK("idle", 1'b0, temp_busy)
  endtask : tp

  task test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Sequence
  initial begin
    int i, j;
    logic [15:0] d;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    xf(1'b1, 8'hDB, 16'hFFFF);
    for (i = 0; i < 5; i++) xf(1'b0, 8'hD7 + 8'(i), 16'h0000);
    $display("test reset values done");
    for (i = 0; i < 40; i++) begin
      d = 16'($random(seed));
      if (i % 4 > 1) d[15:11] = 5'h1C + 5'(i % 3);
      xf(1'b1, 8'hD7 + 8'(i % 4), d);
      xf(1'b0, 8'hD7 + 8'(i % 4), 16'h0000);
    end
    $display("test register access done");
    for (i = 0; i < 32; i++) begin
      xf(1'b1, 8'hD7, (i < 16) ? 16'h0000 : 16'h0001 << (i % 16));
      cap(16'h0001 << (i % 16));
      cap(16'($random(seed)));
    end
    fault_event = 16'h0000;
    $display("test capture mask done");
    for (i = 0; i < 4; i++) begin
      xf(1'b1, 8'hD8, 16'h00F0 | 16'((i == 3) ? 15 : i));
      vs(1'b0, 1'b0);
      for (j = 0; j < m_n + 4; j++) vs(j != m_n + 2, 1'($random(seed)));
    end
    $display("test voltage filter done");
    for (i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      d[15:11] = 5'h1A + 5'(i % 4);
      xf(1'b1, 8'hD9, d);
      xf(1'b1, 8'hDA, {5'h1C, 11'($random(seed))});
      tp(16'($random(seed)));
    end
    tp(16'h8000);
    $display("test temperature done");
    test_done();
  end
endmodule : fault_mask_and_temp_calibration_tb_top

`default_nettype wire
